// File: hdl/sepr_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM command block.
// Assumes: 125 MHz system clock, serial clock supplied by the host.
// Notes: Opcodes, status layout and protection bounds live here only.
package sepr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 8;
  localparam int CYCLE_TIME_US = 100;
  localparam int CYCLE_CYCLES = (CYCLE_TIME_US * 1000) / MCLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int PAGE_W = 6;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] PAGE_BYTES = 7'h40;

  // ----------------------------------------------------------------
  // Opcodes, sent MSB first
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_ARM = 8'h06;
  localparam logic [7:0] OPC_DISARM = 8'h04;
  localparam logic [7:0] OPC_SR_RD = 8'h05;
  localparam logic [7:0] OPC_SR_WR = 8'h01;
  localparam logic [7:0] OPC_MEM_RD = 8'h03;
  localparam logic [7:0] OPC_MEM_WR = 8'h02;

  // ----------------------------------------------------------------
  // Protected range bases, all ranges end at the top address
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] QUARTER_BASE = 15'h6000;
  localparam logic [ADDR_W-1:0] HALF_BASE = 15'h4000;

  // ----------------------------------------------------------------
  // Status byte layout, b7 down to b0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lock;
    logic [2:0] zero;
    logic bp_hi;
    logic bp_lo;
    logic write_latch;
    logic busy_flag;
  } sepr_status_s;

  localparam sepr_status_s STATUS_RST = 8'h00;

  // ----------------------------------------------------------------
  // Link state and decoded frame
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LK_OPC, LK_ADDR, LK_DATA, LK_SRDATA, LK_SROUT, LK_RDOUT, LK_WAIT
  } sepr_link_e;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_ARM, CMD_DISARM, CMD_SRWR, CMD_MEMWR
  } sepr_cmd_e;

  typedef struct packed {
    sepr_cmd_e cmd;
    logic aligned;
    logic [7:0] sr_data;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0] count;
  } sepr_frame_s;

endpackage : sepr_pkg

// File: hdl/sepr_top.sv
// Purpose: Instruction handling of a serial EEPROM slave with protection.
// Assumes: sclk runs only inside frames; cs_n high resets the link shifter and output driver.
// Notes: Link logic runs on sclk, status and write cycles run on mclk.
`timescale 1ns/10ps
module sepr_top import sepr_pkg::*; #(
  parameter int CYCLE_CYCLES_P = CYCLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  output logic miso,
  output logic miso_oe_n
);

  localparam int TMR_W = $clog2(CYCLE_CYCLES_P + 1);

  logic [7:0] mem [0:(2**ADDR_W)-1];
  logic [7:0] pbuf [0:(2**PAGE_W)-1];

  // ----------------------------------------------------------------
  // System side state
  // ----------------------------------------------------------------
  sepr_status_s sr_r;
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic wp_s1_r, wp_s2_r;
  logic seen_r;
  logic pend_sw_r;
  logic [7:0] sr_new_r;
  logic [ADDR_W-1:0] wa_r;
  logic [CNT_W-1:0] wcnt_r;
  logic [CNT_W-1:0] widx_r;
  logic [TMR_W-1:0] tmr_r;

  // ----------------------------------------------------------------
  // Link side state
  // ----------------------------------------------------------------
  sepr_link_e lk_st_r;
  logic [2:0] bit_r;
  logic abyte_r;
  logic rd_r;
  logic [6:0] in_sh_r;
  logic [7:0] out_sh_r;
  logic [ADDR_W-1:0] addr_r;
  sepr_frame_s fr_r;
  logic fr_seq_r;
  sepr_status_s st_k1_r, st_k2_r;
  logic miso_r, miso_oe_n_r;

  logic [7:0] cur_byte;
  logic last_bit;
  logic [ADDR_W-1:0] new_addr;

  assign cur_byte = {in_sh_r, mosi};
  assign last_bit = (bit_r == 3'h7);
  assign new_addr = {addr_r[ADDR_W-9:0], cur_byte};

  // ----------------------------------------------------------------
  // Link shifter, cleared whenever the host deselects
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      lk_st_r <= LK_OPC;
      bit_r <= 3'h0;
      abyte_r <= 1'b0;
      rd_r <= 1'b0;
      in_sh_r <= 7'h00;
      out_sh_r <= 8'h00;
      addr_r <= '0;
    end else begin
      in_sh_r <= cur_byte[6:0];
      bit_r <= bit_r + 3'h1;
      out_sh_r <= {out_sh_r[6:0], 1'b0};
      case (lk_st_r)
        LK_OPC: begin
          if (last_bit) begin
            case (cur_byte)
              OPC_SR_RD: begin
                lk_st_r <= LK_SROUT;
                out_sh_r <= st_k2_r;
              end
              OPC_MEM_RD: begin
                lk_st_r <= st_k2_r.busy_flag ? LK_WAIT : LK_ADDR;
                rd_r <= 1'b1;
              end
              OPC_MEM_WR: lk_st_r <= LK_ADDR;
              OPC_SR_WR: lk_st_r <= LK_SRDATA;
              default: lk_st_r <= LK_WAIT;
            endcase
          end
        end
        LK_ADDR: begin
          if (last_bit) begin
            abyte_r <= 1'b1;
            addr_r <= new_addr;
            if (abyte_r && rd_r) begin
              lk_st_r <= LK_RDOUT;
              out_sh_r <= mem[new_addr];
              addr_r <= new_addr + 15'h0001;
            end else if (abyte_r) begin
              lk_st_r <= LK_DATA;
            end
          end
        end
        LK_SRDATA: begin
          if (last_bit) begin
            lk_st_r <= LK_WAIT;
          end
        end
        LK_SROUT: begin
          if (last_bit) begin
            out_sh_r <= st_k2_r;
          end
        end
        LK_RDOUT: begin
          if (last_bit) begin
            out_sh_r <= mem[addr_r];
            // The counter wraps in its own width at the top address.
            addr_r <= addr_r + 15'h0001;
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Frame record, kept across deselect for the system side to read
  // ----------------------------------------------------------------
  // The record is stable from the last sclk edge onward, so the system
  // side may sample it once the synchronised deselect is seen.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      fr_r <= '0;
      fr_seq_r <= 1'b0;
    end else if (!cs_n) begin
      fr_r.aligned <= last_bit;
      if (lk_st_r == LK_OPC && bit_r == 3'h0) begin
        fr_seq_r <= ~fr_seq_r;
        fr_r.cmd <= CMD_NONE;
      end
      case (lk_st_r)
        LK_OPC: begin
          if (last_bit) begin
            fr_r.count <= '0;
            if (cur_byte == OPC_ARM) begin
              fr_r.cmd <= CMD_ARM;
            end else if (cur_byte == OPC_DISARM) begin
              fr_r.cmd <= CMD_DISARM;
            end
          end
        end
        LK_ADDR: begin
          if (last_bit && abyte_r) begin
            fr_r.addr <= new_addr;
          end
        end
        LK_DATA: begin
          if (last_bit) begin
            fr_r.cmd <= CMD_MEMWR;
            if (fr_r.count != PAGE_BYTES) begin
              fr_r.count <= fr_r.count + 7'h01;
            end
          end
        end
        LK_SRDATA: begin
          if (last_bit) begin
            fr_r.cmd <= CMD_SRWR;
            fr_r.sr_data <= cur_byte;
          end
        end
        LK_WAIT: begin
          if (fr_r.cmd == CMD_SRWR) begin
            fr_r.cmd <= CMD_NONE;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n && lk_st_r == LK_DATA && last_bit) begin
      pbuf[fr_r.count[PAGE_W-1:0]] <= cur_byte;
    end
  end

  // ----------------------------------------------------------------
  // Status into the link domain, and the output driver
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      st_k1_r <= STATUS_RST;
      st_k2_r <= STATUS_RST;
    end else begin
      st_k1_r <= sr_r;
      st_k2_r <= st_k1_r;
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      miso_r <= 1'b0;
      miso_oe_n_r <= 1'b1;
    end else begin
      miso_r <= out_sh_r[7];
      miso_oe_n_r <= !(lk_st_r == LK_SROUT || lk_st_r == LK_RDOUT);
    end
  end

  assign miso = miso_r;
  assign miso_oe_n = miso_oe_n_r;

  // ----------------------------------------------------------------
  // System side: synchronisers and command execution
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      wp_s1_r <= 1'b1;
      wp_s2_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      wp_s1_r <= wp_n;
      wp_s2_r <= wp_s1_r;
    end
  end

  logic exec, hard_lock, prot_hit, done;
  logic go_arm, go_dis, go_sw, go_wr;

  assign exec = cs_s2_r && !cs_s3_r && (fr_seq_r != seen_r);
  assign hard_lock = sr_r.lock && !wp_s2_r;
  assign done = sr_r.busy_flag && (tmr_r == TMR_W'(CYCLE_CYCLES_P - 1));

  always_comb begin
    case ({sr_r.bp_hi, sr_r.bp_lo})
      2'b00: prot_hit = 1'b0;
      2'b01: prot_hit = (fr_r.addr >= QUARTER_BASE);
      2'b10: prot_hit = (fr_r.addr >= HALF_BASE);
      default: prot_hit = 1'b1;
    endcase
  end

  assign go_arm = exec && fr_r.cmd == CMD_ARM;
  assign go_dis = exec && fr_r.cmd == CMD_DISARM;
  assign go_sw = exec && fr_r.cmd == CMD_SRWR && fr_r.aligned &&
                 sr_r.write_latch && !sr_r.busy_flag && !hard_lock;
  assign go_wr = exec && fr_r.cmd == CMD_MEMWR && fr_r.aligned &&
                 sr_r.write_latch && !sr_r.busy_flag && !prot_hit;

  always_ff @(posedge mclk) begin
    if (rst) begin
      seen_r <= 1'b0;
    end else if (cs_s2_r && !cs_s3_r) begin
      seen_r <= fr_seq_r;
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      sr_r <= STATUS_RST;
    end else begin
      if (done && pend_sw_r) begin
        sr_r.lock <= sr_new_r[7];
        sr_r.bp_hi <= sr_new_r[3];
        sr_r.bp_lo <= sr_new_r[2];
      end
      if (go_sw || go_wr) begin
        sr_r.busy_flag <= 1'b1;
      end else if (done) begin
        sr_r.busy_flag <= 1'b0;
      end
      // An arm arriving as a cycle ends still leaves the latch set.
      if (go_arm) begin
        sr_r.write_latch <= 1'b1;
      end else if (go_dis || done) begin
        sr_r.write_latch <= 1'b0;
      end
      sr_r.zero <= 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Self-timed cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      tmr_r <= '0;
      pend_sw_r <= 1'b0;
      sr_new_r <= 8'h00;
      wa_r <= '0;
      wcnt_r <= '0;
    end else if (go_sw || go_wr) begin
      tmr_r <= '0;
      pend_sw_r <= go_sw;
      sr_new_r <= fr_r.sr_data;
      wa_r <= fr_r.addr;
      wcnt_r <= go_wr ? fr_r.count : '0;
    end else if (sr_r.busy_flag && !done) begin
      tmr_r <= tmr_r + TMR_W'(1);
    end
  end

  // Bytes are copied into the array early in the cycle; the remainder
  // of the cycle only keeps the busy flag up for the full write time.
  always_ff @(posedge mclk) begin
    if (rst || go_wr) begin
      widx_r <= '0;
    end else if (sr_r.busy_flag && !pend_sw_r && widx_r < wcnt_r) begin
      widx_r <= widx_r + 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sr_r.busy_flag && !pend_sw_r && widx_r < wcnt_r) begin
      mem[{wa_r[ADDR_W-1:PAGE_W],
           PAGE_W'(wa_r[PAGE_W-1:0] + widx_r[PAGE_W-1:0])}] <=
        pbuf[widx_r[PAGE_W-1:0]];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_wel_end_clear: assert property (@(posedge mclk)
    disable iff (rst) (done && !go_arm) |=> !sr_r.write_latch && !sr_r.busy_flag)
    else $error("write latch or busy not cleared at cycle end");

  a_sw_no_latch: assert property (@(posedge mclk)
    disable iff (rst) ((exec && !sr_r.write_latch && !sr_r.busy_flag) |=> !sr_r.busy_flag))
    else $error("write accepted without write latch");

  a_hard_lock_hold: assert property (@(posedge mclk)
    disable iff (rst)
    (exec && fr_r.cmd == CMD_SRWR && sr_r.lock && !wp_s2_r && !sr_r.busy_flag)
    |=> !sr_r.busy_flag ##1 $stable({sr_r.lock, sr_r.bp_hi, sr_r.bp_lo}))
    else $error("status write ran in hard lock");

  a_nv_late_update: assert property (@(posedge mclk)
    disable iff (rst)
    (sr_r.busy_flag && !done) |=> $stable({sr_r.lock, sr_r.bp_hi, sr_r.bp_lo}))
    else $error("status bits changed before cycle end");

  a_prot_refuse: assert property (@(posedge mclk)
    disable iff (rst) (exec && fr_r.cmd == CMD_MEMWR && prot_hit &&
    !sr_r.busy_flag) |=> !sr_r.busy_flag [*2])
    else $error("write into protected range started");

  a_sw_busy_start: assert property (@(posedge mclk)
    disable iff (rst) go_sw |=> sr_r.busy_flag && sr_r.write_latch && tmr_r == '0)
    else $error("status write cycle did not start");

  a_arm_sets: assert property (@(posedge mclk)
    disable iff (rst) go_arm |=> sr_r.write_latch)
    else $error("arm did not set write latch");

  a_busy_span: assert property (@(posedge mclk)
    disable iff (rst) $rose(sr_r.busy_flag) |-> (tmr_r == '0) ##1 sr_r.busy_flag)
    else $error("busy flag did not cover the cycle");

  a_read_refused: assert property (@(posedge sclk)
    disable iff (cs_n) (lk_st_r == LK_OPC && last_bit &&
    cur_byte == OPC_MEM_RD && st_k2_r.busy_flag) |=> lk_st_r == LK_WAIT)
    else $error("memory read accepted while busy");

  a_read_wrap: assert property (@(posedge sclk)
    disable iff (cs_n) (lk_st_r == LK_RDOUT && last_bit && addr_r == '1)
    |=> addr_r == '0)
    else $error("read address did not wrap to zero");

  c_sw_done: cover property (@(posedge mclk) disable iff (rst)
    done && pend_sw_r);
  c_wr_done: cover property (@(posedge mclk) disable iff (rst)
    done && !pend_sw_r);
  c_read_stream: cover property (@(posedge sclk) disable iff (cs_n)
    lk_st_r == LK_RDOUT && last_bit);
  c_lock_refused: cover property (@(posedge mclk) disable iff (rst)
    exec && fr_r.cmd == CMD_SRWR && hard_lock);

endmodule : sepr_top

// File: dv/sepr_host.sv
// Purpose: Behavioural SPI host that frames commands for the EEPROM block.
// Assumes: Mode 0, serial clock idles low and runs only inside frames.
// Notes: Frames are up to 64 bits, MSB first, first bit is tx[nbits-1].
`timescale 1ns/10ps
module sepr_host #(
  parameter realtime HALF = 7.5
) (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  logic oe_seen;

  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h0;
    oe_seen = 1'h0;
  end

  // ----------------------------------------------------------------
  // One frame
  // ----------------------------------------------------------------
  task automatic xfer(input int nbits, input logic [63:0] tx,
                      output logic [63:0] rx);
    rx = '0;
    oe_seen = 1'h0;
    cs_n = 1'h0;
    for (int i = nbits - 1; i >= 0; i--) begin
      mosi = tx[i];
      #(HALF);
      sclk = 1'h1;
      rx = {rx[62:0], miso};
      if (miso_oe_n === 1'h0) begin
        oe_seen = 1'h1;
      end
      #(HALF);
      sclk = 1'h0;
    end
    // Deselect after the last fall, well before any further rise.
    #(HALF);
    cs_n = 1'h1;
    // A released data line must not keep looking valid.
    mosi = ~mosi;
    #40;
  endtask : xfer
endmodule : sepr_host

// File: dv/tb_sepr_top.sv
// Purpose: Self-checking bench for the EEPROM command block.
// Assumes: Short self-timed cycle through CYCLE_CYCLES_P.
// Notes: Status reads are the main window onto the block.
`timescale 1ns/10ps
module tb_sepr_top import sepr_pkg::*; ;
  localparam int CYC = 200;
  logic mclk, rst, sclk, cs_n, mosi, wp_n, miso, miso_oe_n;
  int fails, checks, ticks;
  logic [63:0] rx;
  logic [7:0] st;
  logic [1:0] bp;
  logic [15:0] bases [3] = '{16'h6000, 16'h4000, 16'h0000};

  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  sepr_top #(.CYCLE_CYCLES_P(CYC)) uut (
    .mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .wp_n(wp_n), .miso(miso), .miso_oe_n(miso_oe_n));

  sepr_host host (
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic cmd(logic [7:0] op);
    host.xfer(8, {56'h0, op}, rx);
  endtask : cmd

  task automatic rd_st(output logic [7:0] s);
    host.xfer(16, {48'h0, OPC_SR_RD, 8'h00}, rx);
    s = rx[7:0];
  endtask : rd_st

  task automatic wr_st(logic [7:0] d);
    cmd(OPC_ARM);
    host.xfer(16, {48'h0, OPC_SR_WR, d}, rx);
  endtask : wr_st

  task automatic mem_wr(logic [15:0] a, logic [7:0] d);
    host.xfer(32, {32'h0, OPC_MEM_WR, a, d}, rx);
  endtask : mem_wr

  // Polls busy with a bounded number of status reads.
  task automatic wait_idle();
    int n;
    n = 0;
    st = 8'hFF;
    while (st[0] !== 1'h0 && n < 40) begin
      rd_st(st);
      n++;
    end
    check("wip_end", st[0], 1'h0);
  endtask : wait_idle

  always @(posedge mclk) begin
    ticks <= ticks + 1;
    if (ticks == 40000) begin
      fails++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'h1;
    wp_n = 1'h1;
    fails = 0;
    checks = 0;
    ticks = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    repeat (4) @(posedge mclk);
    rd_st(st);
    check("st_reset", st, 8'h00);
    check("oe_release", miso_oe_n, 1'h1);
    cmd(OPC_ARM);
    host.xfer(24, {40'h0, OPC_SR_RD, 16'h0000}, rx);
    check("st_repeat", rx[15:0], 16'h0202);
    host.xfer(12, {52'h0, OPC_DISARM, 4'hF}, rx);
    rd_st(st);
    check("st_disarm", st, 8'h00);
    host.xfer(16, {48'h0, OPC_SR_WR, 8'h8C}, rx);
    rd_st(st);
    check("srwr_no_latch", st, 8'h00);
    cmd(OPC_ARM);
    host.xfer(17, {47'h0, OPC_SR_WR, 8'h8C, 1'h0}, rx);
    rd_st(st);
    check("srwr_17bit", st, 8'h02);
    host.xfer(15, {49'h0, OPC_SR_WR, 7'h46}, rx);
    rd_st(st);
    check("srwr_15bit", st, 8'h02);
    wr_st(8'hFF);
    rd_st(st);
    check("srwr_busy", st, 8'h03);
    wait_idle();
    check("srwr_done", st, 8'h8C);
    @(posedge mclk);
    wp_n <= 1'h0;
    wr_st(8'h00);
    rd_st(st);
    check("hard_lock", st, 8'h8E);
    mem_wr(16'h0100, 8'h11);
    rd_st(st);
    check("prot_whole", st, 8'h8E);
    @(posedge mclk);
    wp_n <= 1'h1;
    wr_st(8'h00);
    wait_idle();
    rd_st(st);
    check("lock_left", st, 8'h00);
    @(posedge mclk);
    wp_n <= 1'h0;
    for (int i = 1; i < 4; i++) begin
      bp = 2'(i);
      wr_st({4'h0, bp, 2'h0});
      wait_idle();
      check("bp_set", st, {4'h0, bp, 2'h0});
      cmd(OPC_ARM);
      mem_wr(bases[i-1], 8'h33);
      rd_st(st);
      check("prot_refuse", st, {4'h0, bp, 2'h2});
      if (i < 3) begin
        mem_wr(bases[i-1] - 16'h0001, 8'h33);
        rd_st(st);
        check("prot_below", st, {4'h0, bp, 2'h3});
        wait_idle();
      end
    end
    @(posedge mclk);
    wp_n <= 1'h1;
    wr_st(8'h00);
    wait_idle();
    cmd(OPC_ARM);
    host.xfer(40, {24'h0, OPC_MEM_WR, 16'hFFFE, 16'hC3A5}, rx);
    wait_idle();
    cmd(OPC_ARM);
    host.xfer(40, {24'h0, OPC_MEM_WR, 16'h0000, 16'h5A96}, rx);
    wait_idle();
    check("wr_clears", st, 8'h00);
    host.xfer(56, {8'h0, OPC_MEM_RD, 16'hFFFE, 32'h0}, rx);
    check("rd_wrap", rx[31:0], 32'hC3A55A96);
    cmd(OPC_ARM);
    host.xfer(36, {28'h0, OPC_MEM_WR, 16'h0100, 8'h11, 4'h2}, rx);
    rd_st(st);
    check("wr_unaligned", st, 8'h02);
    mem_wr(16'h0200, 8'h77);
    host.xfer(48, {16'h0, OPC_MEM_RD, 16'h0200, 16'h0000}, rx);
    check("rd_busy_oe", host.oe_seen, 1'h0);
    wait_idle();
    host.xfer(36, {28'h0, OPC_MEM_RD, 16'h0200, 12'h000}, rx);
    check("rd_data", rx[11:4], 8'h77);
    check("rd_oe", host.oe_seen, 1'h1);
    check("rd_abort", miso_oe_n, 1'h1);
    finish_test();
  end
endmodule : tb_sepr_top
